// [inc/bst_pkg.sv]
// Boundary-scan test access port constants, opcodes and state type.
// Assumes one system clock that oversamples the test clock pin.
package bst_pkg;

    localparam int         IR_W            = 3;
    localparam int         ID_W            = 32;
    localparam int         BIST_W          = 2;
    localparam int         CELLS_PER_PIN   = 3;
    localparam int         CELL_IN         = 0;
    localparam int         CELL_OUT        = 1;
    localparam int         CELL_OE         = 2;
    localparam logic [2:0] RESET_RUN_LEN   = 3'h5;
    localparam logic [2:0] RUN_ZERO        = 3'h0;
    localparam logic [2:0] RUN_ONE         = 3'h1;

    localparam logic [IR_W-1:0] OP_EXTEST  = 3'h0;
    localparam logic [IR_W-1:0] OP_IDCODE  = 3'h1;
    localparam logic [IR_W-1:0] OP_SAMPLE  = 3'h2;
    localparam logic [IR_W-1:0] OP_CLAMP   = 3'h3;
    localparam logic [IR_W-1:0] OP_HIGHZ   = 3'h4;
    localparam logic [IR_W-1:0] OP_USBBIST = 3'h5;
    localparam logic [IR_W-1:0] OP_BYPASS  = 3'h7;
    localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;

    // Arbitrary identification value; bit 0 must stay set
    localparam logic [ID_W-1:0] ID_DEFAULT = 32'h0ABC_D001;

    typedef enum logic [3:0] {
        BST_TLR   = 4'h0,
        BST_RTI   = 4'h1,
        BST_SELDR = 4'h3,
        BST_CAPDR = 4'h2,
        BST_SHDR  = 4'h6,
        BST_EX1DR = 4'h7,
        BST_PDR   = 4'h5,
        BST_EX2DR = 4'h4,
        BST_UPDR  = 4'hC,
        BST_SELIR = 4'hD,
        BST_CAPIR = 4'hF,
        BST_SHIR  = 4'hE,
        BST_EX1IR = 4'hA,
        BST_PIR   = 4'hB,
        BST_EX2IR = 4'h9,
        BST_UPIR  = 4'h8
    } bst_state_t;

endpackage

// [logic/bst_sync.sv]
// Two-flop synchroniser for a bus of independent level signals.
// Assumes each bit changes slowly relative to clk_i.
module bst_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            q_o      <= '0;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule

// [logic/bst_tap.sv]
// Boundary-scan test access port with boundary chain over digital pins.
// Assumes tck/tms/tdi come from pins; tck is slow against clk_i.
// Functional notes
// - TMS and TDI are taken only at a rising test clock edge.
// - TDO changes only at a falling test clock edge.
// - TMS and TDI high for five test clocks resets the test logic.
// - Opcodes 111 bypass, 010 sample/preload, 000 extest are decoded.
// - Opcodes 011 clamp, 100 highz, 001 idcode are decoded.
// - Port has exactly four pins: TDO, TDI, TCK, TMS.
// - State machine and register selection follow the 1990 scan standard.
// - Every digital pin has a cell; analog and crystal_output_pin have none.
// - A scan instruction gives access to the USB self-test.
module bst_tap
    import bst_pkg::*;
#(
    parameter int              NUM_PINS = 12,
    parameter logic [ID_W-1:0] ID_VALUE = ID_DEFAULT
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                tck_i,
    input  wire logic                tms_i,
    input  wire logic                tdi_i,
    output logic                     tdo_o,
    output logic                     tdo_oe_o,
    input  wire logic [NUM_PINS-1:0] core_out_i,
    input  wire logic [NUM_PINS-1:0] core_oe_i,
    output logic      [NUM_PINS-1:0] core_in_o,
    input  wire logic [NUM_PINS-1:0] pad_in_i,
    output logic      [NUM_PINS-1:0] pad_out_o,
    output logic      [NUM_PINS-1:0] pad_oe_o,
    output logic                     bist_run_o,
    input  wire logic                bist_done_i,
    input  wire logic                bist_pass_i
);
    localparam int BSR_W = NUM_PINS * CELLS_PER_PIN;

    logic [2:0]          jtag_s;
    logic                tck_s;
    logic                tms_s;
    logic                tdi_s;
    logic [NUM_PINS-1:0] pad_in_s;
    logic                tck_d_reg;

    // Four pins only; no reset pin on this port
    bst_sync #(.W(3)) u_sync_jtag (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({tck_i, tms_i, tdi_i}),
        .q_o   (jtag_s)
    );

    bst_sync #(.W(NUM_PINS)) u_sync_pads (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (pad_in_i),
        .q_o   (pad_in_s)
    );

    assign tck_s = jtag_s[2];
    assign tms_s = jtag_s[1];
    assign tdi_s = jtag_s[0];

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tck_d_reg <= 1'b0;
        end else begin
            tck_d_reg <= tck_s;
        end
    end

    wire tck_rise = tck_s & ~tck_d_reg;
    wire tck_fall = ~tck_s & tck_d_reg;

    bst_state_t          state_reg;
    bst_state_t          state_next;
    logic [2:0]          run_reg;
    logic [IR_W-1:0]     ir_reg;
    logic [IR_W-1:0]     ir_shift_reg;
    logic                byp_reg;
    logic [ID_W-1:0]     id_shift_reg;
    logic [BIST_W-1:0]   bist_shift_reg;
    logic [BSR_W-1:0]    bsr_shift_reg;
    logic [BSR_W-1:0]    bsr_upd_reg;
    logic                tdo_reg;
    logic                tdo_oe_reg;

    // Standard transition graph
    always_comb begin
        case (state_reg)
            BST_TLR:   state_next = tms_s ? BST_TLR   : BST_RTI;
            BST_RTI:   state_next = tms_s ? BST_SELDR : BST_RTI;
            BST_SELDR: state_next = tms_s ? BST_SELIR : BST_CAPDR;
            BST_CAPDR: state_next = tms_s ? BST_EX1DR : BST_SHDR;
            BST_SHDR:  state_next = tms_s ? BST_EX1DR : BST_SHDR;
            BST_EX1DR: state_next = tms_s ? BST_UPDR  : BST_PDR;
            BST_PDR:   state_next = tms_s ? BST_EX2DR : BST_PDR;
            BST_EX2DR: state_next = tms_s ? BST_UPDR  : BST_SHDR;
            BST_UPDR:  state_next = tms_s ? BST_SELDR : BST_RTI;
            BST_SELIR: state_next = tms_s ? BST_TLR   : BST_CAPIR;
            BST_CAPIR: state_next = tms_s ? BST_EX1IR : BST_SHIR;
            BST_SHIR:  state_next = tms_s ? BST_EX1IR : BST_SHIR;
            BST_EX1IR: state_next = tms_s ? BST_UPIR  : BST_PIR;
            BST_PIR:   state_next = tms_s ? BST_EX2IR : BST_PIR;
            BST_EX2IR: state_next = tms_s ? BST_UPIR  : BST_SHIR;
            BST_UPIR:  state_next = tms_s ? BST_SELDR : BST_RTI;
            default:   state_next = BST_TLR;
        endcase
    end

    // Instruction decode
    wire is_extest = (ir_reg == OP_EXTEST);
    wire is_sample = (ir_reg == OP_SAMPLE);
    wire is_idcode = (ir_reg == OP_IDCODE);
    wire is_clamp  = (ir_reg == OP_CLAMP);
    wire is_highz  = (ir_reg == OP_HIGHZ);
    wire is_bist   = (ir_reg == OP_USBBIST);
    wire sel_bsr   = is_extest | is_sample;
    // Unused opcodes fall to bypass as the standard asks
    wire sel_byp   = ~(sel_bsr | is_idcode | is_bist);
    wire pins_test = is_extest | is_clamp | is_highz;

    wire in_tlr  = (state_reg == BST_TLR);
    wire cap_dr  = (state_reg == BST_CAPDR);
    wire sh_dr   = (state_reg == BST_SHDR);
    wire upd_dr  = (state_reg == BST_UPDR);
    wire cap_ir  = (state_reg == BST_CAPIR);
    wire sh_ir   = (state_reg == BST_SHIR);
    wire upd_ir  = (state_reg == BST_UPIR);
    wire both_hi = tms_s & tdi_s;
    wire run_hit = both_hi && (run_reg == RESET_RUN_LEN - RUN_ONE);

    wire dr_out = sel_byp   ? byp_reg          :
                  sel_bsr   ? bsr_shift_reg[0] :
                  is_idcode ? id_shift_reg[0]  : bist_shift_reg[0];
    wire tdo_next = sh_ir ? ir_shift_reg[0] : dr_out;

    // Capture/shift only on the test clock rising edge
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= BST_TLR;
            run_reg   <= RUN_ZERO;
        end else if (tck_rise) begin
            run_reg   <= both_hi ? (run_hit ? RUN_ZERO : run_reg + RUN_ONE) : RUN_ZERO;
            state_reg <= run_hit ? BST_TLR : state_next;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ir_reg       <= OP_IDCODE;
            ir_shift_reg <= IR_CAPTURE;
        end else if (tck_rise) begin
            if (in_tlr) begin
                ir_reg <= OP_IDCODE;
            end else if (upd_ir) begin
                ir_reg <= ir_shift_reg;
            end
            if (cap_ir) begin
                ir_shift_reg <= IR_CAPTURE;
            end else if (sh_ir) begin
                ir_shift_reg <= {tdi_s, ir_shift_reg[IR_W-1:1]};
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            byp_reg        <= 1'b0;
            id_shift_reg   <= '0;
            bist_shift_reg <= '0;
        end else if (tck_rise) begin
            if (cap_dr) begin
                byp_reg        <= 1'b0;
                id_shift_reg   <= ID_VALUE;
                bist_shift_reg <= {bist_pass_i, bist_done_i};
            end else if (sh_dr) begin
                byp_reg        <= tdi_s;
                id_shift_reg   <= {tdi_s, id_shift_reg[ID_W-1:1]};
                bist_shift_reg <= {tdi_s, bist_shift_reg[BIST_W-1:1]};
            end
        end
    end

    // Cell i*3+0 input, +1 output value, +2 output enable
    logic [BSR_W-1:0] bsr_capture;
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_cell
            assign bsr_capture[g*CELLS_PER_PIN+CELL_IN]  = pad_in_s[g];
            assign bsr_capture[g*CELLS_PER_PIN+CELL_OUT] = core_out_i[g];
            assign bsr_capture[g*CELLS_PER_PIN+CELL_OE]  = core_oe_i[g];
        end
    endgenerate

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bsr_shift_reg <= '0;
            bsr_upd_reg   <= '0;
        end else if (tck_rise) begin
            if (in_tlr) begin
                bsr_upd_reg <= '0;
            end else if (upd_dr && sel_bsr) begin
                bsr_upd_reg <= bsr_shift_reg;
            end
            if (cap_dr && sel_bsr) begin
                bsr_shift_reg <= bsr_capture;
            end else if (sh_dr && sel_bsr) begin
                bsr_shift_reg <= {tdi_s, bsr_shift_reg[BSR_W-1:1]};
            end
        end
    end

    // TDO launched on the falling edge, sampled by tester on next rise
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tdo_reg    <= 1'b0;
            tdo_oe_reg <= 1'b0;
        end else if (tck_fall) begin
            tdo_reg    <= tdo_next;
            tdo_oe_reg <= sh_dr | sh_ir;
        end
    end

    // Pad and core muxes; crystal_output_pin is not in this chain
    logic [NUM_PINS-1:0] pad_out_next;
    logic [NUM_PINS-1:0] pad_oe_next;
    logic [NUM_PINS-1:0] core_in_next;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            wire upd_in  = bsr_upd_reg[g*CELLS_PER_PIN+CELL_IN];
            wire upd_out = bsr_upd_reg[g*CELLS_PER_PIN+CELL_OUT];
            wire upd_oe  = bsr_upd_reg[g*CELLS_PER_PIN+CELL_OE];
            assign pad_out_next[g] = pins_test ? upd_out : core_out_i[g];
            assign pad_oe_next[g]  = is_highz ? 1'b0 :
                                     pins_test ? upd_oe : core_oe_i[g];
            assign core_in_next[g] = pins_test ? upd_in : pad_in_s[g];
        end
    endgenerate

    // Registered outputs add one clk of latency to functional pin paths
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pad_out_o  <= '0;
            pad_oe_o   <= '0;
            core_in_o  <= '0;
            bist_run_o <= 1'b0;
        end else begin
            pad_out_o  <= pad_out_next;
            pad_oe_o   <= pad_oe_next;
            core_in_o  <= core_in_next;
            bist_run_o <= is_bist && (state_reg == BST_RTI);
        end
    end

    assign tdo_o    = tdo_reg;
    assign tdo_oe_o = tdo_oe_reg;
endmodule

// [testbench/bst_tap_props.sv]
// Checker on the scan pins of the test access port.
// Assumes tck_i is slow against clk_i: 5 clk low, 3 clk high in the bench.
module bst_tap_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tck_i,
    input wire logic tdo_o,
    input wire logic tdo_oe_o,
    input wire logic bist_run_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Pin fall seen through synchroniser and edge detect, 2 to 4 clk late
    sequence s_after_fall;
        !tck_i && !$past(tck_i, 2) && $past(tck_i, 5);
    endsequence

    sequence s_quiet;
        $stable(tdo_o) && $stable(tdo_oe_o) && $stable(bist_run_o);
    endsequence

    a_tdo_on_fall: assert property ($changed(tdo_o) |-> s_after_fall)
        else $error("tdo moved away from a test clock fall");
    a_oe_on_fall: assert property ($changed(tdo_oe_o) |-> s_after_fall)
        else $error("tdo enable moved away from a test clock fall");
    a_idle_quiet: assert property ($stable(tck_i)[*6] |-> s_quiet)
        else $error("scan outputs moved with the test clock still");
    a_oe_span: assert property ($rose(tdo_oe_o) |-> tdo_oe_o[*8])
        else $error("shift window shorter than one test clock");
    a_bist_gap: assert property ($fell(tdo_oe_o) |-> !bist_run_o[*8])
        else $error("self-test ran before update and idle");
    a_bist_no_shift: assert property (bist_run_o |-> !tdo_oe_o)
        else $error("self-test running while shifting");
    a_reset_quiet: assert property (disable iff (1'b0)
        rst_i |-> !tdo_o && !tdo_oe_o && !bist_run_o)
        else $error("outputs active during reset");
    a_release_calm: assert property ($fell(rst_i) |-> !tdo_oe_o[*4])
        else $error("tdo driven just after reset release");
endmodule

bind bst_tap bst_tap_props u_props (
    .clk_i(clk_i), .rst_i(rst_i), .tck_i(tck_i),
    .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .bist_run_o(bist_run_o)
);

// [testbench/bst_tester.sv]
// Tester model for the four scan pins of the test access port.
// Assumes its tasks are called just after a falling clk_i edge.
module bst_tester (
    input  wire logic clk_i,
    input  wire logic tdo_i,
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic b;

    // Test clock stands low between frames; idle pins at pull-up level
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end

    // Five clk low, three high: tdo has settled well before the rise
    task automatic bit_io(input logic ms, input logic di, output logic dout);
        tms_o = ms;
        tdi_o = di;
        repeat (5) @(negedge clk_i);
        dout = tdo_i;
        tck_o = 1'b1;
        repeat (3) @(negedge clk_i);
        tck_o = 1'b0;
    endtask

    task automatic move(input logic [7:0] seq, input int n);
        for (int i = 0; i < n; i++) begin
            bit_io(seq[i], 1'b1, b);
        end
    endtask

    // Shift LSB first, leave via update to idle
    task automatic scan(input int n, input logic [31:0] din, output logic [31:0] dout);
        dout = '0;
        for (int i = 0; i < n; i++) begin
            bit_io(i == n - 1, din[i], dout[i]);
        end
        move(8'h01, 2);
    endtask

    task automatic ir(input logic [2:0] op, output logic [31:0] cap);
        move(8'h03, 4);
        scan(3, {29'h0, op}, cap);
    endtask

    task automatic dr(input int n, input logic [31:0] din, output logic [31:0] dout);
        move(8'h01, 3);
        scan(n, din, dout);
    endtask

    task automatic reset5;
        move(8'h1F, 5);
        move(8'h00, 1);
    endtask
endmodule

// [testbench/test_boundary_scan_tap_port.sv]
// Self-checking bench for the boundary-scan test access port.
// Assumes the tester model drives the scan pins; checker is bound.
module test_boundary_scan_tap_port
    import bst_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NP = 8;
    logic          clk_i = 1'b0;
    logic          rst_i;
    logic          tdo_line;
    logic          tck, tms, tdi, tdo, tdo_oe, bist_run;
    logic          bist_done = 1'b0;
    logic          bist_pass = 1'b0;
    logic [NP-1:0] core_out = 8'hC3;
    logic [NP-1:0] core_oe = 8'h0F;
    logic [NP-1:0] pad_in = 8'h5A;
    logic [NP-1:0] core_in, pad_out, pad_oe;
    logic [31:0]   got;
    int            fail_count = 0;
    int            comparisons = 0;

    always #25 clk_i = ~clk_i;

    // No pull on TDO: a released line reads inverted, so a stray sample shows
    assign tdo_line = tdo_oe ? tdo : ~tdo;

    bst_tap #(.NUM_PINS(NP)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .tdo_o(tdo), .tdo_oe_o(tdo_oe), .core_out_i(core_out), .core_oe_i(core_oe),
        .core_in_o(core_in), .pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
        .bist_run_o(bist_run), .bist_done_i(bist_done), .bist_pass_i(bist_pass)
    );
    bst_tester tst (.clk_i(clk_i), .tdo_i(tdo_line), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));

    task automatic check(input logic [31:0] g, input logic [31:0] e, input string m);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("Error at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask

    // Cell 3i input, 3i+1 out value, 3i+2 out enable
    function automatic logic [31:0] cells(input logic [7:0] a, b, c);
        cells = '0;
        for (int i = 0; i < NP; i++) begin
            cells[3*i +: 3] = {c[i], b[i], a[i]};
        end
    endfunction

    task automatic t_bypass;
        logic [2:0] ops [4] = '{OP_BYPASS, OP_CLAMP, OP_HIGHZ, 3'h6};
        foreach (ops[k]) begin
            tst.ir(ops[k], got);
            check(got, {29'h0, IR_CAPTURE}, "ir capture");
            tst.dr(8, 32'hA5, got);
            check(got, 32'h4A, "bypass");
        end
    endtask

    task automatic t_sample;
        tst.ir(OP_SAMPLE, got);
        check(32'({pad_oe, pad_out, core_in}), 32'({core_oe, core_out, pad_in}), "pass");
        tst.dr(24, cells(8'h00, 8'h96, 8'hF0), got);
        check(got, cells(pad_in, core_out, core_oe), "sample");
    endtask

    task automatic t_latch;
        logic [2:0] ops [3] = '{OP_EXTEST, OP_CLAMP, OP_HIGHZ};
        foreach (ops[k]) begin
            tst.ir(ops[k], got);
            // New opcode reaches the pad registers one clk after the update
            repeat (2) @(negedge clk_i);
            check(32'(pad_oe), (ops[k] == OP_HIGHZ) ? 32'h0 : 32'hF0, "pad oe");
            check(32'(core_in), 32'h0, "core in");
            if (ops[k] != OP_HIGHZ) check(32'(pad_out), 32'h96, "pad out");
        end
    endtask

    task automatic t_bist;
        bist_done = 1'b1;
        tst.ir(OP_USBBIST, got);
        repeat (2) @(negedge clk_i);
        check(32'(bist_run), 32'h1, "bist run");
        tst.dr(2, 32'h0, got);
        check(got, 32'h1, "bist status");
        bist_pass = 1'b1;
        tst.dr(2, 32'h0, got);
        check(got, 32'h3, "bist status");
    endtask

    task automatic t_idcode;
        tst.dr(32, 32'h0, got);
        check(got, ID_DEFAULT, "idcode");
    endtask

    task automatic wrap_up;
        $display("Comparisons %0d, errors %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        rst_i = 1'b1;
        repeat (3) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (8) @(negedge clk_i);
        tst.move(8'h00, 1);
        t_idcode();
        t_bypass();
        t_sample();
        t_latch();
        t_bist();
        tst.ir(OP_BYPASS, got);
        tst.reset5();
        t_idcode();
        wrap_up();
    end

    // Hang guard
    initial begin
        #1_000_000;
        fail_count++;
        wrap_up();
    end
endmodule
